// File: cpg_top.sv
// cascaded pulse-width generator: main channel, registers, secondary link
//
// What this block does
// - main period lasts period limit plus one clocks, 16-bit counter.
// - main active part lasts duty value plus one clocks, own register.
// - divider covers slowest 16-bit period up to clock rate, duty to continuous.
// - main disabled without inversion rests low.
// - main enabled, not inverted: high for duty part, then low.
// - main inverted and disabled rests high.
// - main enabled and inverted: low for duty part, then high.
// - disabling main returns it to rest level until enabled again.
// - each secondary counts main output rising edges in 8 bits, divide by 256.
// - both secondaries share the main clock, each with its own duty.
// - secondary duty is 8 bits, active cycles out of 256.
// - each secondary inversion bit flips rest level and switching phase.
// - secondaries have no enable; they run only while main runs.
// - main control bits, limit and duty read back; secondary duties write-only.
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module cpg_top (
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [cpg_pkg::CPG_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output wire logic [31:0]                   wb_dat_o,
  output wire logic                          wb_ack_o,
  output wire logic                          main_pulse_channel,
  output wire logic                          secondary_channel_a,
  output wire logic                          secondary_channel_b
);
  import cpg_pkg::*;

  typedef struct packed {
    cpg_bus_e                          bus;
    logic [31:0]                       rdat;
    logic                              en;
    logic                              inv;
    logic [CPG_NSEC-1:0]               sinv;
    logic [CPG_MAIN_W-1:0]             limit;
    logic [CPG_MAIN_W-1:0]             duty;
    logic [CPG_NSEC-1:0][CPG_SEC_W-1:0] sduty;
    logic [CPG_MAIN_W-1:0]             cnt;
    logic                              out;
    logic                              out_d;
  } cpg_main_s;

  cpg_main_s   st_reg;
  cpg_main_s   st_next;
  logic [7:0]  word_adr;
  logic [31:0] rd_mux;
  logic        active;
  logic        req;

  cpg_sec_if sec_link ();

  // ==========================================================================
  // lane-wise merge of a write into a narrow register
  function automatic logic [15:0] cpg_merge16(
    input logic [15:0] old,
    input logic [31:0] dat,
    input logic [3:0]  sel
  );
    logic [15:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    return res;
  endfunction

  // ==========================================================================
  // read decode
  assign word_adr = {wb_adr_i[7:2], 2'b00};
  assign req      = wb_cyc_i && wb_stb_i;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (word_adr)
      CPG_OFS_CTRL: begin
        rd_mux[CPG_CTRL_EN]     = st_reg.en;
        rd_mux[CPG_CTRL_INV]    = st_reg.inv;
        rd_mux[CPG_CTRL_SINV_A] = st_reg.sinv[0];
        rd_mux[CPG_CTRL_SINV_B] = st_reg.sinv[1];
      end
      CPG_OFS_LIMIT: begin
        rd_mux[15:0] = st_reg.limit;
      end
      CPG_OFS_DUTY: begin
        rd_mux[15:0] = st_reg.duty;
      end
      CPG_OFS_STATUS: begin
        rd_mux[CPG_STAT_OUT]                    = st_reg.out;
        rd_mux[CPG_STAT_SOUT +: CPG_NSEC]       = sec_link.out;
        rd_mux[CPG_STAT_EN]                     = st_reg.en;
        rd_mux[CPG_STAT_CNT +: CPG_MAIN_W]      = st_reg.cnt;
      end
      // secondary duty words are write-only and read as zero
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================================
  // main channel compare; duty at or past the limit gives a steady level
  assign active = (st_reg.cnt <= st_reg.duty);

  always_comb begin
    st_next = st_reg;

    // bus: answer one cycle after the request, commit the write on the
    // edge where the master sees ack
    case (st_reg.bus)
      CPG_BUS_IDLE: begin
        if (req) begin
          st_next.bus  = CPG_BUS_ACK;
          st_next.rdat = rd_mux;
        end
      end
      CPG_BUS_ACK: begin
        st_next.bus = CPG_BUS_IDLE;
        if (req && wb_we_i) begin
          case (word_adr)
            CPG_OFS_CTRL: begin
              if (wb_sel_i[0]) begin
                st_next.en      = wb_dat_i[CPG_CTRL_EN];
                st_next.inv     = wb_dat_i[CPG_CTRL_INV];
                st_next.sinv[0] = wb_dat_i[CPG_CTRL_SINV_A];
                st_next.sinv[1] = wb_dat_i[CPG_CTRL_SINV_B];
              end
            end
            CPG_OFS_LIMIT: begin
              st_next.limit = cpg_merge16(st_reg.limit, wb_dat_i, wb_sel_i);
            end
            CPG_OFS_DUTY: begin
              st_next.duty = cpg_merge16(st_reg.duty, wb_dat_i, wb_sel_i);
            end
            CPG_OFS_SDUTY_A: begin
              if (wb_sel_i[0]) begin
                st_next.sduty[0] = wb_dat_i[7:0];
              end
            end
            CPG_OFS_SDUTY_B: begin
              if (wb_sel_i[0]) begin
                st_next.sduty[1] = wb_dat_i[7:0];
              end
            end
            default: begin
              st_next.bus = CPG_BUS_IDLE;
            end
          endcase
        end
      end
      default: begin
        st_next.bus = CPG_BUS_IDLE;
      end
    endcase

    // period counter; >= so a limit written below the count still wraps
    if (!st_reg.en) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= st_reg.limit) begin
      st_next.cnt = '0;
    end else begin
      st_next.cnt = CPG_MAIN_W'(st_reg.cnt + 16'h0001);
    end

    // level: duty part first, inversion swaps both phase and rest level
    st_next.out   = st_reg.en ? (active ^ st_reg.inv) : st_reg.inv;
    st_next.out_d = st_reg.out;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg.bus   <= CPG_BUS_IDLE;
      st_reg.rdat  <= 32'h0000_0000;
      st_reg.en    <= 1'b0;
      st_reg.inv   <= 1'b0;
      st_reg.sinv  <= '0;
      st_reg.limit <= CPG_LIMIT_RST;
      st_reg.duty  <= CPG_DUTY_RST;
      st_reg.sduty <= {CPG_NSEC{CPG_SDUTY_RST}};
      st_reg.cnt   <= '0;
      st_reg.out   <= 1'b0;
      st_reg.out_d <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // secondary link: rising edge of the main output steps the secondaries
  assign sec_link.tick = st_reg.en && st_reg.out && !st_reg.out_d;
  assign sec_link.run  = st_reg.en;
  assign sec_link.duty = st_reg.sduty;
  assign sec_link.inv  = st_reg.sinv;

  cpg_sec u_sec (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sec     (sec_link.chan)
  );

  assign wb_ack_o            = (st_reg.bus == CPG_BUS_ACK);
  assign wb_dat_o            = st_reg.rdat;
  assign main_pulse_channel  = st_reg.out;
  assign secondary_channel_a = sec_link.out[0];
  assign secondary_channel_b = sec_link.out[1];

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_limit_read;
    !wb_ack_o && req && !wb_we_i && word_adr == CPG_OFS_LIMIT;
  endsequence

  sequence s_duty_read;
    !wb_ack_o && req && !wb_we_i && word_adr == CPG_OFS_DUTY;
  endsequence

  a_period_wrap: assert property (st_reg.en && st_reg.cnt >= st_reg.limit
    |=> st_reg.cnt == 16'h0000) else $error("main period did not wrap");

  a_period_step: assert property (st_reg.en && st_reg.cnt < st_reg.limit
    |=> st_reg.cnt == CPG_MAIN_W'($past(st_reg.cnt) + 16'h0001))
    else $error("main counter did not step");

  a_duty_high: assert property (
    st_reg.en && !st_reg.inv && st_reg.cnt <= st_reg.duty |=> main_pulse_channel)
    else $error("main not high in duty part");

  a_duty_inv: assert property (
    st_reg.en && st_reg.inv && st_reg.cnt <= st_reg.duty |=> !main_pulse_channel)
    else $error("inverted main not low in duty part");

  a_tail_level: assert property (st_reg.en && st_reg.cnt > st_reg.duty
    |=> main_pulse_channel == $past(st_reg.inv)) else $error("main tail level wrong");

  // rest level follows the invert bit one cycle late, so compare with last cycle's bit
  a_rest_level: assert property (!st_reg.en ##1 !st_reg.en
    |-> main_pulse_channel == $past(st_reg.inv)) else $error("main not at rest level");

  a_limit_read: assert property (s_limit_read
    |=> wb_ack_o && wb_dat_o == {16'h0000, st_reg.limit})
    else $error("limit readback wrong");

  a_duty_read: assert property (s_duty_read
    |=> wb_ack_o && wb_dat_o == {16'h0000, st_reg.duty})
    else $error("duty readback wrong");

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  a_reset_rest: assert property (@(posedge clock) disable iff (1'b0) sys_rst
    |=> !main_pulse_channel && !secondary_channel_a && !secondary_channel_b && !st_reg.en)
    else $error("outputs not low after reset");

endmodule

// File: cpg_pkg.sv
// shared constants and types of the cascaded pulse-width generator
package cpg_pkg;

  // ==========================================================================
  // register map (byte addresses on the wishbone port)
  localparam int        CPG_ADR_W       = 8;
  localparam logic [7:0] CPG_OFS_CTRL    = 8'h00;
  localparam logic [7:0] CPG_OFS_LIMIT   = 8'h04;
  localparam logic [7:0] CPG_OFS_DUTY    = 8'h08;
  localparam logic [7:0] CPG_OFS_SDUTY_A = 8'h0C;
  localparam logic [7:0] CPG_OFS_SDUTY_B = 8'h10;
  localparam logic [7:0] CPG_OFS_STATUS  = 8'h14;

  // ==========================================================================
  // control field positions
  localparam int CPG_CTRL_EN     = 0;
  localparam int CPG_CTRL_INV    = 1;
  localparam int CPG_CTRL_SINV_A = 2;
  localparam int CPG_CTRL_SINV_B = 3;

  // ==========================================================================
  // status field positions
  localparam int CPG_STAT_OUT   = 0;
  localparam int CPG_STAT_SOUT  = 1;
  localparam int CPG_STAT_EN    = 3;
  localparam int CPG_STAT_CNT   = 16;

  // ==========================================================================
  // widths and reset values
  localparam int           CPG_MAIN_W    = 16;
  localparam int           CPG_SEC_W     = 8;
  localparam int           CPG_NSEC      = 2;
  localparam logic [15:0]  CPG_LIMIT_RST = 16'hFFFF;
  localparam logic [15:0]  CPG_DUTY_RST  = 16'h7FFF;
  localparam logic [7:0]   CPG_SDUTY_RST = 8'h80;
  localparam logic [7:0]   CPG_SEC_LAST  = 8'hFF;

  // ==========================================================================
  // bus handshake states
  typedef enum logic [1:0] {
    CPG_BUS_IDLE = 2'b01,
    CPG_BUS_ACK  = 2'b10
  } cpg_bus_e;

endpackage

// File: cpg_sec_if.sv
// link between the main channel and the two secondary channels
`timescale 1ns/1ps
interface cpg_sec_if;
  import cpg_pkg::*;

  logic                              tick;
  logic                              run;
  logic [CPG_NSEC-1:0][CPG_SEC_W-1:0] duty;
  logic [CPG_NSEC-1:0]               inv;
  logic [CPG_NSEC-1:0]               out;

  modport ctl  (output tick, output run, output duty, output inv, input out);
  modport chan (input tick, input run, input duty, input inv, output out);
endinterface

// File: cpg_sec.sv
// two secondary channels stepped by the main channel output
`timescale 1ns/1ps
module cpg_sec (
  input wire logic clock,
  input wire logic sys_rst,
  cpg_sec_if.chan  sec
);
  import cpg_pkg::*;

  typedef struct packed {
    logic [CPG_NSEC-1:0][CPG_SEC_W-1:0] cnt;
    logic [CPG_NSEC-1:0]               out;
  } cpg_sec_s;

  cpg_sec_s                          st_reg;
  cpg_sec_s                          st_next;
  logic [CPG_NSEC-1:0]               lvl;
  logic [CPG_NSEC-1:0][CPG_SEC_W-1:0] cnt_step;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // per-channel compare and step
  genvar gi;
  generate
    for (gi = 0; gi < CPG_NSEC; gi++) begin : g_ch
      // active below duty, inversion last; forced to rest level when stopped
      assign lvl[gi] = sec.run ? ((st_reg.cnt[gi] < sec.duty[gi]) ^ sec.inv[gi])
                               : sec.inv[gi];
      // 8-bit wrap gives the fixed divide by 256
      assign cnt_step[gi] = sec.tick ? CPG_SEC_W'(st_reg.cnt[gi] + 8'h01)
                                     : st_reg.cnt[gi];

      a_sec_wrap: assert property (
        sec.run && sec.tick && st_reg.cnt[gi] == CPG_SEC_LAST |=> st_reg.cnt[gi] == 8'h00)
        else $error("secondary counter did not wrap");
      a_sec_level: assert property (sec.run && st_reg.cnt[gi] < sec.duty[gi]
        |=> sec.out[gi] != $past(sec.inv[gi])) else $error("secondary not active");
      a_sec_idle: assert property (!sec.run
        |=> sec.out[gi] == $past(sec.inv[gi])) else $error("secondary not at rest");
    end
  endgenerate

  // ==========================================================================
  // state update
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < CPG_NSEC; i++) begin
      // restart from zero each time the main channel starts
      st_next.cnt[i] = sec.run ? cnt_step[i] : '0;
    end
    st_next.out = lvl;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sec.out = st_reg.out;

endmodule

// File: tb_top.sv
// self-checking bench of the cascaded pulse-width generator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import cpg_pkg::*;

  logic              clock = 1'b0;
  logic              sys_rst = 1'b1;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [7:0]        wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h0;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              main_pulse_channel;
  logic              secondary_channel_a;
  logic              secondary_channel_b;
  int                fail_count = 0;
  int                n_compared = 0;
  int                cnt_m, rise_m, fall_m, cnt_a, cnt_b;
  logic [31:0]       rd;

  cpg_top DUT (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .main_pulse_channel(main_pulse_channel),
    .secondary_channel_a(secondary_channel_a), .secondary_channel_b(secondary_channel_b));

  always #20 clock = ~clock;

  // ==========================================================================
  // bus cycles: request held until the edge that samples ack
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      $display("Error ack expected 1 seen %0h", wb_ack_o);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(1'b1, a, d, 4'hF, q);
  endtask

  // ==========================================================================
  // output observation over a whole number of periods
  task automatic observe(input int n);
    logic pm;
    cnt_m = 0; rise_m = 0; fall_m = 0; cnt_a = 0; cnt_b = 0;
    @(posedge clock);
    pm = main_pulse_channel;
    repeat (n) begin
      @(posedge clock);
      cnt_m += int'(main_pulse_channel === 1'b1);
      cnt_a += int'(secondary_channel_a === 1'b1);
      cnt_b += int'(secondary_channel_b === 1'b1);
      rise_m += int'(pm === 1'b0 && main_pulse_channel === 1'b1);
      fall_m += int'(pm === 1'b1 && main_pulse_channel === 1'b0);
      pm = main_pulse_channel;
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset_regs();
    `CHK("main out", 1'b0, main_pulse_channel)
    `CHK("sec a out", 1'b0, secondary_channel_a)
    `CHK("sec b out", 1'b0, secondary_channel_b)
    wb_cycle(1'b0, CPG_OFS_CTRL, 32'h0, 4'hF, rd);
    `CHK("ctrl", 32'h0, rd)
    wb_cycle(1'b0, CPG_OFS_LIMIT, 32'h0, 4'hF, rd);
    `CHK("limit", {16'h0, CPG_LIMIT_RST}, rd)
    wb_cycle(1'b0, CPG_OFS_DUTY, 32'h0, 4'hF, rd);
    `CHK("duty", {16'h0, CPG_DUTY_RST}, rd)
    // only the low lane lands, upper byte keeps its reset ones
    wb_cycle(1'b1, CPG_OFS_LIMIT, 32'h1234_56AB, 4'h1, rd);
    wb_cycle(1'b0, CPG_OFS_LIMIT, 32'h0, 4'hF, rd);
    `CHK("limit lane", 32'h0000_FFAB, rd)
    wr(CPG_OFS_DUTY, 32'hFFFF_A5C3);
    wb_cycle(1'b0, CPG_OFS_DUTY, 32'h0, 4'hF, rd);
    `CHK("duty 16b", 32'h0000_A5C3, rd)
    wr(CPG_OFS_SDUTY_A, 32'h0000_0033);
    wb_cycle(1'b0, CPG_OFS_SDUTY_A, 32'h0, 4'hF, rd);
    `CHK("sduty wo", 32'h0, rd)
    wb_cycle(1'b0, 8'h3C, 32'h0, 4'hF, rd);
    `CHK("unmapped", 32'h0, rd)
    $display("test reset_regs done");
  endtask

  task automatic t_main(input int lim, input int dut, input logic inv);
    int act;
    int starts;
    int exp_act;
    wr(CPG_OFS_LIMIT, 32'(lim));
    wr(CPG_OFS_DUTY, 32'(dut));
    wr(CPG_OFS_CTRL, {30'h0, inv, 1'b1});
    repeat (8) @(posedge clock);
    observe(10 * (lim + 1));
    act = inv ? 10 * (lim + 1) - cnt_m : cnt_m;
    starts = inv ? fall_m : rise_m;
    exp_act = (dut >= lim) ? 10 * (lim + 1) : 10 * (dut + 1);
    `CHK("active cycles", exp_act, act)
    `CHK("periods", (dut >= lim) ? 0 : 10, starts)
    wr(CPG_OFS_CTRL, {30'h0, inv, 1'b0});
    repeat (3) @(posedge clock);
    observe(20);
    `CHK("rest level", inv ? 20 : 0, cnt_m)
    wb_cycle(1'b0, CPG_OFS_STATUS, 32'h0, 4'hF, rd);
    `CHK("status idle", {31'h0, inv}, rd)
    $display("test main limit %0d duty %0d inv %0d done", lim, dut, inv);
  endtask

  task automatic t_sec(input logic [7:0] da, input logic [7:0] db, input logic [3:0] ctl);
    int ea;
    int eb;
    wr(CPG_OFS_CTRL, 32'h0);
    wr(CPG_OFS_SDUTY_A, {24'h0, da});
    wr(CPG_OFS_SDUTY_B, {24'h0, db});
    wr(CPG_OFS_LIMIT, 32'h1);
    wr(CPG_OFS_DUTY, 32'h0);
    wr(CPG_OFS_CTRL, {28'h0, ctl});
    repeat (20) @(posedge clock);
    // main period of 2 clocks, so one secondary period is 512 clocks
    observe(512);
    ea = 2 * int'(da);
    eb = 2 * int'(db);
    `CHK("sec a active", ctl[2] ? 512 - ea : ea, cnt_a)
    `CHK("sec b active", ctl[3] ? 512 - eb : eb, cnt_b)
    wr(CPG_OFS_CTRL, {28'h0, ctl[3:1], 1'b0});
    repeat (3) @(posedge clock);
    observe(600);
    `CHK("sec a stopped", ctl[2] ? 600 : 0, cnt_a)
    `CHK("sec b stopped", ctl[3] ? 600 : 0, cnt_b)
    wb_cycle(1'b0, CPG_OFS_STATUS, 32'h0, 4'hF, rd);
    `CHK("status sec", {28'h0, 1'b0, ctl[3:2], ctl[1]}, rd)
    $display("test sec %0h %0h ctl %0h done", da, db, ctl);
  endtask

  // reset in mid-run with everything enabled and inverted
  task automatic t_reset_mid();
    wr(CPG_OFS_CTRL, 32'h0000_000F);
    repeat (6) @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    `CHK("main out rst", 1'b0, main_pulse_channel)
    `CHK("sec a out rst", 1'b0, secondary_channel_a)
    `CHK("sec b out rst", 1'b0, secondary_channel_b)
    wb_cycle(1'b0, CPG_OFS_CTRL, 32'h0, 4'hF, rd);
    `CHK("ctrl rst", 32'h0, rd)
    $display("test reset_mid done");
  endtask

  // ==========================================================================
  // verdict
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset_regs();
    t_main(3, 1, 1'b0);
    t_main(4, 0, 1'b1);
    t_main(4, 4, 1'b0);
    t_main(2, 1, 1'b1);
    t_sec(8'h40, 8'hC0, 4'h9);
    t_sec(8'h00, 8'hFF, 4'h1);
    t_sec(8'hFF, 8'h00, 4'hD);
    t_reset_mid();
    report_and_stop();
  end

  // a run of about 3900 clocks is expected; this allows ample margin
  initial begin
    repeat (40000) @(posedge clock);
    fail_count++;
    $display("Error watchdog expected done seen hang");
    report_and_stop();
  end
endmodule
